//--- verif/pfde_engine_sva.sv
// Port-level checker for the shading and dither engine
module pfde_engine_sva (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Register bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Pixel stream
  input wire logic        pix_valid,
  input wire logic        pix_in_video,
  input wire logic        out_valid,
  input wire logic        out_in_video,
  input wire logic [7:0]  out_r,
  input wire logic [7:0]  out_g,
  input wire logic [7:0]  out_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Properties, all in the pixel clock domain
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence rd_addr;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence pix_run;
    pix_valid [*3];
  endsequence
  chk_valid_burst: assert property (pix_run |=> out_valid && $past(out_valid) && $past(out_valid, 2))
    else $error("output pixels do not follow an input run");
  chk_valid_gap: assert property (!pix_valid |=> !out_valid)
    else $error("output pixel without an input pixel");
  chk_region_follow: assert property (pix_valid |=> out_in_video == $past(pix_in_video))
    else $error("output region differs from input region");
  chk_pixel_hold: assert property (!pix_valid |=> $stable({out_r, out_g, out_b}))
    else $error("output pixel changed with no input");
  chk_rdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data changed outside a read");
  chk_read_ready: assert property (rd_addr |=> hreadyout)
    else $error("read data phase was stalled");
  chk_ready_high: assert property (hreadyout)
    else $error("slave inserted a wait state");
  chk_resp_okay: assert property (!hresp)
    else $error("slave gave an error response");
  chk_rdata_upper: assert property (hrdata[31:14] == 18'h0)
    else $error("unused read data bits are set");
endmodule : pfde_engine_sva

//--- verif/pfde_panel_model.sv
// Behavioural flat panel that counts the pixels it is shown
module pfde_panel_model (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // Pixels from the engine
  input wire logic       out_valid,
  input wire logic [7:0] out_r
);
  timeunit 1ns;
  timeprecision 1ns;
  int pix_count;
  int on_count;
  // One panel dot per pixel; a 1-bit panel lights when the level is set
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pix_count <= 0;
      on_count  <= 0;
    end else if (out_valid === 1'b1) begin
      pix_count <= pix_count + 1;
      on_count  <= on_count + int'(out_r);
    end
  end
endmodule : pfde_panel_model

//--- verif/tb_top.sv
// Self-checking bench for the shading and dither engine
module tb_top import pfde_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, pix_x = 3'h0, pix_y = 3'h0;
  logic        pix_valid = 1'b0, pix_frame_start = 1'b0, pix_in_video = 1'b0;
  logic [7:0]  pix_v = 8'h0, out_r, out_g, out_b;
  logic        hreadyout, hresp, out_valid, out_in_video;
  logic [31:0] hrdata;
  logic [7:0]  nib_t [6] = '{8'h01, 8'h02, 8'h03, 8'h07, 8'h07, 8'h0b};
  logic [7:0]  val_t [6] = '{8'h40, 8'h30, 8'h08, 8'h08, 8'h78, 8'h38};
  int          exp_t [6] = '{2, 3, 1, 0, 14, 6};
  int          mismatches = 0, total_checks = 0, base;
  // 100 MHz pixel clock
  always #5 clock = ~clock;
  pfde_engine #(.CHAN_W(8), .FRAME_W(4)) pfde_engine_i (.clock(clock), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pix_valid(pix_valid), .pix_frame_start(pix_frame_start),
    .pix_in_video(pix_in_video), .pix_x(pix_x), .pix_y(pix_y), .pix_r(pix_v),
    .pix_g(pix_v), .pix_b(pix_v), .out_valid(out_valid), .out_in_video(out_in_video),
    .out_r(out_r), .out_g(out_g), .out_b(out_b));
  pfde_panel_model pfde_panel_model_i (.clock(clock), .rst(rst), .out_valid(out_valid),
    .out_r(out_r));
  // ----------------------------------------------------------------
  // Bus, pixel and comparison tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    total_checks++;
    if (seen !== expected) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, expected);
    end
  endtask : check
  // Single word transfer; waits on hready in both phases
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic rd_check(input logic [31:0] a, input logic [31:0] expected);
    bus(a, 1'b0, 32'h0);
    check(q, expected);
  endtask : rd_check
  task automatic pix(input logic start, input logic vid);
    @(posedge clock);
    pix_valid <= 1'b1; pix_frame_start <= start; pix_in_video <= vid;
    @(posedge clock);
    pix_valid <= 1'b0; pix_frame_start <= 1'b0;
  endtask : pix
  task automatic complete_run();
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (50000) @(posedge clock);
    mismatches++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd_check(32'h0, 32'h40); rd_check(32'h4, 32'h0); rd_check(32'h8, 32'h40);
    rd_check(32'hc, 32'h23); rd_check(32'h3c, 32'h0);
    rd_check(32'h10, 32'h0303);
    bus(32'h3c, 1'b1, 32'hff);
    rd_check(32'h3c, 32'h0);
    // 2-bit panel, 24-bit source: the limit caps the pattern at six bits
    bus(32'hc, 1'b1, 32'h22);
    for (int n = 0; n < 8; n++) begin
      bus(32'h0, 1'b1, 32'hc0 | n);
      rd_check(32'h10, 32'h0600 | ((n > 6) ? 6 : n));
    end
    bus(32'h0, 1'b1, 32'h40);
    rd_check(32'h10, 32'h0606);
    // 1-bit panel: shading shares the depth budget with the dither
    bus(32'hc, 1'b1, 32'h21);
    for (int n = 0; n < 4; n++) begin
      bus(32'h4, 1'b1, n);
      bus(32'h10, 1'b0, 32'h0);
      check(q & 32'h3f, (n == 0) ? 32'h06 : (n == 1) ? 32'h15 : (n == 2) ? 32'h1b : 32'h22);
    end
    bus(32'hc, 1'b1, 32'h01);
    bus(32'h4, 1'b1, 32'h01);
    rd_check(32'h10, 32'h0412);
    bus(32'hc, 1'b1, 32'h21);
    bus(32'h4, 1'b1, 32'h30);
    bus(32'h8, 1'b1, 32'hc1);
    rd_check(32'h10, 32'h2106);
    // Mixed regions back to back, every pixel must come out once
    base = pfde_panel_model_i.pix_count;
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      pix_valid <= 1'b1; pix_in_video <= i[0]; pix_x <= i[2:0];
    end
    @(posedge clock);
    pix_valid <= 1'b0;
    repeat (2) @(posedge clock);
    check(pfde_panel_model_i.pix_count - base, 6);
    // Shading duty over one full period, one pixel per frame, no dither
    bus(32'h0, 1'b1, 32'hc0);
    pix_x <= 3'h0;
    for (int t = 0; t < 6; t++) begin
      bus(32'h4, 1'b1, nib_t[t]);
      pix_v <= val_t[t];
      base = pfde_panel_model_i.on_count;
      repeat (2 << nib_t[t][1:0]) pix(1'b1, 1'b0);
      repeat (2) @(posedge clock);
      check(pfde_panel_model_i.on_count - base, exp_t[t]);
      check({out_g, out_b}, 16'h0);
    end
    complete_run();
  end
endmodule : tb_top
bind pfde_engine pfde_engine_sva pfde_engine_sva_i (.clock(clock), .rst(rst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .pix_valid(pix_valid),
  .pix_in_video(pix_in_video), .out_valid(out_valid), .out_in_video(out_in_video),
  .out_r(out_r), .out_g(out_g), .out_b(out_b));

//--- verilog/pfde_engine.sv
// Frame-rate shading and spatial dither stage for flat-panel pixels
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`include "pfde_params.svh"
module pfde_engine
  import pfde_pkg::*;
#(
  parameter int CHAN_W  = 8,
  parameter int FRAME_W = 4
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Expanded pixels from resolution compensation
  input  wire logic              pix_valid,
  input  wire logic              pix_frame_start,
  input  wire logic              pix_in_video,
  input  wire logic [2:0]        pix_x,
  input  wire logic [2:0]        pix_y,
  input  wire logic [CHAN_W-1:0] pix_r,
  input  wire logic [CHAN_W-1:0] pix_g,
  input  wire logic [CHAN_W-1:0] pix_b,
  // Pixels to the panel interface, low-aligned at the panel depth
  output logic                   out_valid,
  output logic                   out_in_video,
  output logic [CHAN_W-1:0]      out_r,
  output logic [CHAN_W-1:0]      out_g,
  output logic [CHAN_W-1:0]      out_b
);

  // Shade arithmetic assumes 8-bit channels and a 16-frame counter
  if (CHAN_W != 8 || FRAME_W != 4) begin : g_bad_param
    $error("pfde_engine: CHAN_W must be 8 and FRAME_W 4");
  end

  // ----------------------------------------------------------------
  // Data path overview
  // ----------------------------------------------------------------
  // Pixels arrive already expanded by resolution compensation, one per
  // cycle at most, and leave one cycle later at the panel depth. Each
  // channel is cut into three parts: the panel level, the shading bits
  // and the dither bits. The shading bits are compared against the frame
  // counter, offset by screen position, so the pixel lights on that many
  // frames of each period whenever the graphics period is no shorter than its own and no dither bits are used. The dither bits are compared against an
  // ordered matrix entry of the pixel's cell, so neighbours share the
  // fraction in space instead of in time. Both parts are merged into one
  // threshold, which keeps a single compare per channel.
  // Limitation: the position offset uses only the low two bits of the
  // column and row, so the shading phase repeats every four pixels and
  // the dither matrix every eight.

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  logic [7:0]  gfx_ctrl_r;
  logic [7:0]  shared_r;
  logic [7:0]  vid_ctrl_r;
  logic [7:0]  panel_r;
  logic        wr_pend_r;
  logic [3:0]  wr_idx_r;
  logic [31:0] hrdata_r;
  logic [3:0]  frame_r;
  logic [5:0]  gfx_eff;
  logic [5:0]  vid_eff;

  // Address phase decode; only word slots 0..4 are mapped
  wire         addr_ok  = hsel && hready && htrans[1];
  wire  [3:0]  addr_idx = haddr[5:2];
  wire         in_map   = haddr[31:6] == 26'h0;
  wire  [31:0] rd_word  =
      !in_map                         ? 32'h0 :
      addr_idx == `PFDE_ADDR_GFX_CTRL ? {24'h0, gfx_ctrl_r} :
      addr_idx == `PFDE_ADDR_SHARED   ? {24'h0, shared_r} :
      addr_idx == `PFDE_ADDR_VID_CTRL ? {24'h0, vid_ctrl_r} :
      addr_idx == `PFDE_ADDR_PANEL    ? {24'h0, panel_r} :
      addr_idx == `PFDE_ADDR_STATUS   ? {16'h0, 2'h0, vid_eff, 2'h0, gfx_eff} :
      32'h0;
  wire  [3:0]  wr_idx   = in_map ? addr_idx : 4'hf;

  // Zero-wait slave: read data prepared in the address phase
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 4'hf;
      hrdata_r  <= 32'h0;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_idx_r  <= wr_idx;
      if (addr_ok && !hwrite) begin
        hrdata_r <= rd_word;
      end
    end
  end

  // Write strobes per register, taken from the index captured in the address phase
  wire         wr_gfx    = wr_pend_r && (wr_idx_r == `PFDE_ADDR_GFX_CTRL);
  wire         wr_shared = wr_pend_r && (wr_idx_r == `PFDE_ADDR_SHARED);
  wire         wr_vid    = wr_pend_r && (wr_idx_r == `PFDE_ADDR_VID_CTRL);
  wire         wr_panel  = wr_pend_r && (wr_idx_r == `PFDE_ADDR_PANEL);

  // Write data lands in the data phase; unmapped writes are dropped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gfx_ctrl_r <= `PFDE_RST_CTRL;
      shared_r   <= `PFDE_RST_SHARED;
      vid_ctrl_r <= `PFDE_RST_CTRL;
      panel_r    <= `PFDE_RST_PANEL;
    end else begin
      if (wr_gfx) begin
        gfx_ctrl_r <= hwdata[7:0];
      end
      if (wr_shared) begin
        shared_r <= hwdata[7:0];
      end
      if (wr_vid) begin
        vid_ctrl_r <= hwdata[7:0];
      end
      if (wr_panel) begin
        panel_r <= hwdata[7:0];
      end
    end
  end

  // Response flops: the slave never stalls and never errors, yet both pins
  // leave a flop so the bus sees clean levels straight out of reset
  logic        hreadyout_r;
  logic        hresp_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;                                          // Zero wait states
      hresp_r     <= 1'b0;                                          // Always OKAY
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;

  // ----------------------------------------------------------------
  // Depth resolution
  // ----------------------------------------------------------------
  // Panel bits per primary, clamped to 1..8
  wire  [3:0]  pan_bits = (panel_r[3:0] == 4'h0) ? 4'h1 :
                          (panel_r[3:0] > 4'h8)  ? 4'h8 : panel_r[3:0];
  // Source bits per primary: 15/16-bit sources give 5, 24-bit gives 8
  wire  [3:0]  src_bits = (panel_r[5:4] == 2'h2) ? 4'h8 : 4'h5;

  // Returns {shading bits, dither bits} for one setting. The panel and source
  // depths come in as arguments so the result follows every register write.
  function automatic logic [5:0] pfde_resolve(input logic [7:0] ctrl,
                                              input logic [3:0] nib,
                                              input logic [3:0] pan,
                                              input logic [3:0] src);
    int m;
    int d;
    int room;
    int cap;
    // Shading depth from the frame_rate_shading option
    m = 0;
    case (pfde_frs_type'(nib[1:0]))
      PFDE_FRS_4:  m = 2;
      PFDE_FRS_8:  m = 3;
      PFDE_FRS_16: m = 4;
      default:     m = 0;
    endcase
    // Depth budget between panel and source; shading takes its share first
    room = int'(src) - int'(pan);
    if (room < 0) begin
      room = 0;
    end
    if (m > room) begin
      m = room;
    end
    // Automatic pattern size, or the fixed one for three-bit panels with shading off
    if (pan == `PFDE_TFT3_BITS && m == 0) begin
      d = `PFDE_TFT3_DITH;
    end else begin
      d = `PFDE_MAX_DITH;
    end
    // Override limits the added bits to the programmed count
    if (ctrl[`PFDE_CTRL_OVR] && int'(ctrl[2:0]) < d) begin
      d = int'(ctrl[2:0]);
    end
    if (!ctrl[`PFDE_CTRL_EN]) begin
      d = 0;
    end
    // What is left of the budget after shading bounds the dither
    cap = room - m;
    // Full depth is kept for four-frame shading; longer periods add no dither beyond seven bits of panel, shading and dither
    if (m > 2) begin
      if (`PFDE_NOT4_CAP - int'(pan) - m < cap) begin
        cap = `PFDE_NOT4_CAP - int'(pan) - m;
      end
    end
    if (cap < 0) begin
      cap = 0;
    end
    if (d > cap) begin
      d = cap;
    end
    if (d > `PFDE_MAX_DITH) begin
      d = `PFDE_MAX_DITH;
    end
    pfde_resolve = {3'(m), 3'(d)};
  endfunction : pfde_resolve

  // Separate settings per region
  assign gfx_eff = pfde_resolve(gfx_ctrl_r, shared_r[3:0], pan_bits, src_bits);
  assign vid_eff = pfde_resolve(vid_ctrl_r, shared_r[7:4], pan_bits, src_bits);

  // Per-pixel choice of setting
  wire  [5:0]  cur_eff  = pix_in_video ? vid_eff : gfx_eff;
  wire  [3:0]  cur_nib  = pix_in_video ? shared_r[7:4] : shared_r[3:0];
  wire  [2:0]  frs_bits = cur_eff[5:3];
  wire  [2:0]  dit_bits = cur_eff[2:0];
  wire  [3:0]  frac_w   = {1'b0, frs_bits} + {1'b0, dit_bits};
  wire  [3:0]  tot_bits = pan_bits + frac_w;
  wire  [7:0]  frs_mask = (8'h1 << frs_bits) - 8'h1;
  wire  [7:0]  dit_mask = (8'h1 << dit_bits) - 8'h1;
  wire  [7:0]  frac_msk = (8'h1 << frac_w) - 8'h1;
  wire  [7:0]  top_lvl  = (8'h1 << pan_bits) - 8'h1;
  wire         mask_on  = frs_bits == 3'h4;

  // ----------------------------------------------------------------
  // Frame counter
  // ----------------------------------------------------------------
  // Period follows the graphics shading setting so it never jumps mid-frame by region;
  // with shading off the wrap mask is zero and the counter rests at frame 0
  wire  [2:0]  gfx_frs  = gfx_eff[5:3];
  wire  [3:0]  gfx_per  = 4'((8'h1 << gfx_frs) - 8'h1);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_r <= 4'h0;
    end else if (pix_valid && pix_frame_start) begin
      frame_r <= (frame_r + 4'h1) & gfx_per;
    end
  end

  // Phase offset per position spreads on-frames to cut flicker: two pixels
  // with the same shade in one row of four light on different frames, which keeps
  // the panel's average drive steady from frame to frame
  wire  [7:0]  phase    = {4'h0, frame_r + {pix_y[1:0], pix_x[1:0]}} & frs_mask;
  // Ordered matrix of 8x8; its top bits form the smaller patterns.
  // Taking the top bits keeps each smaller pattern balanced, so every
  // cell of a 2x1 up to an 8x4 pattern sees each threshold once.
  wire  [5:0]  bayer    = {pix_x[0] ^ pix_y[0], pix_y[0], pix_x[1] ^ pix_y[1],
                           pix_y[1], pix_x[2] ^ pix_y[2], pix_y[2]};
  wire  [7:0]  pat_val  = 8'(bayer >> (3'h6 - dit_bits));
  wire  [7:0]  thresh   = 8'(pat_val << frs_bits) | phase;

  // ----------------------------------------------------------------
  // Per-channel shading
  // ----------------------------------------------------------------
  // Masked sixteen-frame shades: drop the flicker-prone duties. The nearest
  // kept duty is chosen, so a masked shade moves by one step at most.
  function automatic logic [3:0] pfde_mask_shade(input logic [3:0] s,
                                                 input logic [1:0] sel);
    logic [3:0] r;
    r = s;
    // Both masked options drop the lightest and heaviest partial duties
    if (sel != PFDE_MASK_NONE) begin
      if (s == 4'h1) begin
        r = 4'h0;
      end
      if (s == 4'hf) begin
        r = 4'he;
      end
    end
    // Four masked shades also drop the two duties around half
    if (sel == PFDE_MASK_FOUR) begin
      if (s == 4'h7) begin
        r = 4'h6;
      end
      if (s == 4'h9) begin
        r = 4'ha;
      end
    end
    pfde_mask_shade = r;
  endfunction : pfde_mask_shade

  logic [CHAN_W-1:0] chan_in  [3];
  logic [CHAN_W-1:0] chan_out [3];
  logic [CHAN_W-1:0] out_r_r;
  logic [CHAN_W-1:0] out_g_r;
  logic [CHAN_W-1:0] out_b_r;
  logic              out_valid_r;
  logic              out_vid_r;

  assign chan_in[0] = pix_r;
  assign chan_in[1] = pix_g;
  assign chan_in[2] = pix_b;

  // Each channel: base level plus one step when the fraction beats the threshold.
  // The top panel level has no step above it, so it is held rather than wrapped;
  // a full-scale source therefore shows steadily on instead of flickering.
  for (genvar c = 0; c < 3; c++) begin : g_chan
    wire [7:0] base   = chan_in[c] >> (4'h8 - pan_bits);
    wire [7:0] frac   = (chan_in[c] >> (4'h8 - tot_bits)) & frac_msk;
    wire [7:0] fr_hi  = (frac >> dit_bits) & frs_mask;
    wire [3:0] shade  = mask_on ? pfde_mask_shade(fr_hi[3:0], cur_nib[3:2]) : fr_hi[3:0];
    wire [7:0] frac_m = 8'({4'h0, shade} << dit_bits) | (frac & dit_mask);
    wire       step   = frac_m > thresh;
    assign chan_out[c] = (step && base != top_lvl) ? base + 8'h1 : base;
  end

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  // One output pixel per input pixel, one cycle later; levels and region
  // hold between pixels so the panel interface may sample them late
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_valid_r <= 1'b0;
      out_vid_r   <= 1'b0;
      out_r_r     <= '0;
      out_g_r     <= '0;
      out_b_r     <= '0;
    end else begin
      out_valid_r <= pix_valid;
      if (pix_valid) begin
        out_vid_r <= pix_in_video;
        out_r_r   <= chan_out[0];
        out_g_r   <= chan_out[1];
        out_b_r   <= chan_out[2];
      end
    end
  end

  assign out_valid    = out_valid_r;
  assign out_in_video = out_vid_r;
  assign out_r        = out_r_r;
  assign out_g        = out_g_r;
  assign out_b        = out_b_r;

endmodule : pfde_engine

//--- verilog/pfde_params.svh
// Constants of the panel frame-rate shading and dither engine
`ifndef PFDE_PARAMS_SVH
`define PFDE_PARAMS_SVH
// ----------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PFDE_ADDR_GFX_CTRL   4'h0
`define PFDE_ADDR_SHARED     4'h1
`define PFDE_ADDR_VID_CTRL   4'h2
`define PFDE_ADDR_PANEL      4'h3
`define PFDE_ADDR_STATUS     4'h4
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PFDE_CTRL_OVR        7
`define PFDE_CTRL_EN         6
`define PFDE_RST_CTRL        8'h40
`define PFDE_RST_SHARED      8'h00
`define PFDE_RST_PANEL       8'h23
`define PFDE_MAX_DITH        6
`define PFDE_NOT4_CAP        7
`define PFDE_TFT3_BITS       4'h3
`define PFDE_TFT3_DITH       3
`endif

//--- verilog/pfde_pkg.sv
// Types of the panel frame-rate shading and dither engine
package pfde_pkg;
  // Frame-rate shading options held in a nibble
  typedef enum logic [1:0] {
    PFDE_FRS_OFF = 2'h0,
    PFDE_FRS_4   = 2'h1,
    PFDE_FRS_8   = 2'h2,
    PFDE_FRS_16  = 2'h3
  } pfde_frs_type;
  // Shade masking in the sixteen-frame option
  typedef enum logic [1:0] {
    PFDE_MASK_NONE = 2'h0,
    PFDE_MASK_TWO  = 2'h1,
    PFDE_MASK_FOUR = 2'h2
  } pfde_mask_type;
endpackage : pfde_pkg
